// [pkg/mem_access_pkg.sv]
/*
 * Constants, states and carriers of the debug memory access engine.
 * Assumes a 25 MHz system clock and a JTAG clock well below it.
 */
package mem_access_pkg;
	// ****************************************
	// Register selection and field layout
	// ****************************************
	localparam logic [6:0] IDX_CTRL_STATUS = 7'h07;
	localparam logic [6:0] IDX_TARGET_ADDR = 7'h09;
	localparam logic [6:0] IDX_DATA_WORD = 7'h0A;
	localparam int SEL_BITS = 8;
	localparam int POS_TRIGGER = 31;
	localparam int POS_DIR = 30;
	localparam int POS_SIZE = 27;
	localparam int POS_MAP = 24;
	localparam int POS_PRIO = 22;
	localparam int POS_BURST = 21;
	localparam int POS_COUNT = 2;
	localparam int POS_ERR = 1;
	localparam int POS_VALID = 0;
	localparam logic [31:0] RESET_CTRL_STATUS = 32'h0000_0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [7:0] RESET_SELECT = 8'h00;
	// ****************************************
	// Size, priority and burst encodings
	// ****************************************
	localparam logic [2:0] SZ_BYTE = 3'h0;
	localparam logic [2:0] SZ_HALF = 3'h1;
	localparam logic [2:0] SZ_WORD = 3'h2;
	localparam logic [2:0] SZ_DOUBLE = 3'h3;
	localparam logic [1:0] PRIO_HIGHEST = 2'h3;
	localparam int BURST_WORDS = 8;
	localparam logic [2:0] BURST_ALIGN_MASK = 3'h7;
	// ****************************************
	// States and carriers
	// ****************************************
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
		TAP_EX1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
	} tap_e;
	typedef enum logic [1:0] {
		ENG_IDLE = 2'h0,
		ENG_WAIT_DATA = 2'h1,
		ENG_BUS = 2'h2
	} eng_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0] size;
		logic write;
		logic burst;
		logic high_prio;
	} bus_req_s;
endpackage

// [core/mem_access_engine.sv]
/*
 * Debug memory access engine: a JTAG-reached register port of three
 * registers and a system bus master that runs transfers beside the CPU.
 * Assumes an outside instruction decoder raises GATEWAY_SEL while the
 * gateway command is loaded, and a bus that answers each beat with ACK or ERR.
 */
// Behaviour
// - Transfers run while the processor keeps executing; no halt needed.
// - Bus transfers are physical, bypassing address translation and cache.
// - Trigger bit 31 written 1 starts a transfer; reads 0 when done or idle.
// - Bit 30 picks direction: 0 read into data register, 1 write from it.
// - Size bits 29..27: byte, half, word; double-word only with burst.
// - Reserved size codes 100..111 act as word accesses.
// - Priority bits 23..22: 11 highest, all other codes lowest.
// - Bit 21 zero gives single bus cycles, one gives burst operation.
// - Count bits 15..2 give how many accesses a single-cycle transfer performs, zero giving one; a burst runs two word beats per count.
// - A failed access shows error set and valid clear.
// - A good read shows valid set and error clear.
// - A good write shows error and valid both clear.
// - Write in progress shows valid only; read in progress neither; never both.
// - An 8-bit selection scan, LSB first, gives index and direction; data follows.
// - Indices: 0x7 control-status, 0x9 address, 0xA data.
// - Ready pin asserts when a transfer completes without error.
// - Burst ignores low three address bits; 32 bytes pass through an 8-word buffer.
`timescale 1ns/10ps
module mem_access_engine (
	input wire logic CLK, // System clock
	input wire logic RSTN, // Asynchronous reset, active low
	input wire logic GATEWAY_SEL, // Gateway command loaded in the debug port
	input wire logic TCK, // JTAG clock
	input wire logic TMS, // JTAG mode select
	input wire logic TDI, // JTAG data in
	output logic TDO, // JTAG data out
	output logic RDY_N, // Transfer done without error, active low
	output logic BUS_VALID, // Bus request pending
	output mem_access_pkg::bus_req_s BUS_REQ, // Bus request fields
	input wire logic BUS_ACK, // Beat finished
	input wire logic BUS_ERR, // Beat failed
	input wire logic [31:0] BUS_RDATA // Read data, right-justified
);
	import mem_access_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [1:0] eff_size(input logic [2:0] sz);
		eff_size = (sz == SZ_BYTE || sz == SZ_HALF) ? sz[1:0] : SZ_WORD[1:0];
	endfunction

	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		size_mask = (sz == SZ_BYTE[1:0]) ? 32'h0000_00FF :
			(sz == SZ_HALF[1:0]) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] tck_s, tms_s, tdi_s, gw_s;
	logic tck_d;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tck_s <= 2'h0;
			tms_s <= 2'h0;
			tdi_s <= 2'h0;
			gw_s <= 2'h0;
			tck_d <= 1'b0;
		end else begin
			tck_s <= {tck_s[0], TCK};
			tms_s <= {tms_s[0], TMS};
			tdi_s <= {tdi_s[0], TDI};
			gw_s <= {gw_s[0], GATEWAY_SEL};
			tck_d <= tck_s[1];
		end
	end
	logic tck_rise, tck_fall;
	assign tck_rise = tck_s[1] & ~tck_d;
	assign tck_fall = ~tck_s[1] & tck_d;

	// ****************************************
	// Test access state and data scan
	// ****************************************
	tap_e tap, next_tap;
	logic [31:0] sr, next_sr;
	logic data_phase, next_data_phase;
	logic [6:0] sel_idx, next_sel_idx;
	logic sel_wr, next_sel_wr;
	logic tdo, next_tdo;
	logic [31:0] rd_value;
	logic upd_pulse, cap_pulse;

	assign cap_pulse = tck_rise && tap == TAP_CAP_DR && gw_s[1] && data_phase && !sel_wr;
	assign upd_pulse = tck_rise && tap == TAP_UPD_DR && gw_s[1] && data_phase && sel_wr;

	function automatic tap_e tap_step(input tap_e s, input logic m);
		unique case (s)
			TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_step = m ? TAP_EX1_DR : TAP_SHIFT_DR;
			TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_step = m ? TAP_EX2_DR : TAP_PAUSE_DR;
			TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_step = m ? TAP_EX1_IR : TAP_SHIFT_IR;
			TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_step = m ? TAP_EX2_IR : TAP_PAUSE_IR;
			TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	always_comb begin
		next_tap = tap;
		next_sr = sr;
		next_data_phase = data_phase;
		next_sel_idx = sel_idx;
		next_sel_wr = sel_wr;
		next_tdo = tdo;
		if (tck_fall) begin
			next_tdo = sr[0];
		end
		if (tck_rise) begin
			next_tap = tap_step(tap, tms_s[1]);
			if (tap == TAP_RESET || !gw_s[1]) begin
				next_data_phase = 1'b0;
			end else if (tap == TAP_CAP_DR) begin
				next_sr = data_phase ? rd_value : {24'h0, RESET_SELECT};
			end else if (tap == TAP_SHIFT_DR) begin
				next_sr = {tdi_s[1], sr[31:1]};
			end else if (tap == TAP_UPD_DR) begin
				if (!data_phase) begin
					next_sel_idx = sr[31:25];
					next_sel_wr = sr[32 - SEL_BITS];
				end
				next_data_phase = ~data_phase;
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tap <= TAP_RESET;
			sr <= RESET_WORD;
			data_phase <= 1'b0;
			sel_idx <= RESET_SELECT[7:1];
			sel_wr <= RESET_SELECT[0];
			tdo <= 1'b0;
		end else begin
			tap <= next_tap;
			sr <= next_sr;
			data_phase <= next_data_phase;
			sel_idx <= next_sel_idx;
			sel_wr <= next_sel_wr;
			tdo <= next_tdo;
		end
	end
	assign TDO = tdo;

	// ****************************************
	// Registers and bus engine
	// ****************************************
	eng_e eng, next_eng;
	logic trig, next_trig, dir, next_dir, burst_select, next_bst, err, next_err, dv, next_dv;
	logic [2:0] sz, next_sz, map, next_map;
	logic [1:0] pr, next_pr;
	logic [13:0] cnt, next_cnt;
	logic [31:0] addr, next_addr, data, next_data, cur, next_cur;
	logic [14:0] beats, next_beats;
	logic [2:0] bptr, next_bptr;
	logic [31:0] buf_mem [BURST_WORDS];
	logic [31:0] next_buf_mem [BURST_WORDS];
	logic rdy, next_rdy;
	logic [1:0] bsz;

	assign bsz = burst_select ? SZ_WORD[1:0] : eff_size(sz);
	assign rd_value = (sel_idx == IDX_CTRL_STATUS) ?
		{trig, dir, sz, map, pr, burst_select, 5'h00, cnt, err, dv} :
		(sel_idx == IDX_TARGET_ADDR) ? addr :
		(sel_idx == IDX_DATA_WORD) ?
		((burst_select && dv && !dir) ? buf_mem[bptr] : data) : RESET_WORD;

	always_comb begin
		next_eng = eng;
		next_trig = trig;
		next_dir = dir;
		next_bst = burst_select;
		next_err = err;
		next_dv = dv;
		next_sz = sz;
		next_map = map;
		next_pr = pr;
		next_cnt = cnt;
		next_addr = addr;
		next_data = data;
		next_cur = cur;
		next_beats = beats;
		next_bptr = bptr;
		next_buf_mem = buf_mem;
		next_rdy = rdy;
		// Only a finished burst read walks the buffer; a write fill must not move
		if (cap_pulse && sel_idx == IDX_DATA_WORD && burst_select && dv && !dir) begin
			next_bptr = bptr + 3'h1;
		end
		unique case (eng)
			ENG_IDLE: begin
				if (upd_pulse && sel_idx == IDX_TARGET_ADDR) begin
					next_addr = sr;
				end else if (upd_pulse && sel_idx == IDX_DATA_WORD) begin
					next_data = sr;
				end else if (upd_pulse && sel_idx == IDX_CTRL_STATUS) begin
					next_trig = sr[POS_TRIGGER];
					next_dir = sr[POS_DIR];
					next_sz = sr[POS_SIZE +: 3];
					next_map = sr[POS_MAP +: 3];
					next_pr = sr[POS_PRIO +: 2];
					next_bst = sr[POS_BURST];
					next_cnt = sr[POS_COUNT +: 14];
					if (sr[POS_TRIGGER]) begin
						next_rdy = 1'b0;
						next_bptr = 3'h0;
						next_err = 1'b0;
						next_dv = sr[POS_DIR];
						next_cur = sr[POS_BURST] ?
							(addr & ~{29'h0, BURST_ALIGN_MASK}) : addr;
						next_beats = sr[POS_BURST] ? {sr[POS_COUNT +: 14], 1'b0} :
							(sr[POS_COUNT +: 14] == 14'h0 ? 15'h1 : {1'b0, sr[POS_COUNT +: 14]});
						next_eng = sr[POS_DIR] ? ENG_WAIT_DATA : ENG_BUS;
					end
				end
			end
			ENG_WAIT_DATA: begin
				if (upd_pulse && sel_idx == IDX_DATA_WORD) begin
					next_data = sr;
					if (burst_select) begin
						next_buf_mem[bptr] = sr;
						next_bptr = bptr + 3'h1;
						if (bptr == 3'(BURST_WORDS - 1)) begin
							next_eng = ENG_BUS;
						end
					end else begin
						next_eng = ENG_BUS;
					end
				end else if (upd_pulse && sel_idx == IDX_TARGET_ADDR) begin
					next_addr = sr;
				end
			end
			ENG_BUS: begin
				if (BUS_ERR) begin
					next_err = 1'b1;
					next_dv = 1'b0;
					next_trig = 1'b0;
					next_eng = ENG_IDLE;
				end else if (BUS_ACK) begin
					if (!dir && burst_select) begin
						next_buf_mem[bptr] = BUS_RDATA;
					end else if (!dir) begin
						next_data = BUS_RDATA & size_mask(bsz);
					end
					if (burst_select) begin
						next_bptr = bptr + 3'h1;
					end
					next_cur = cur + (32'h1 << bsz);
					next_beats = beats - 15'h1;
					if (beats <= 15'h1) begin
						next_trig = 1'b0;
						next_dv = ~dir;
						next_err = 1'b0;
						next_rdy = 1'b1;
						next_bptr = 3'h0;
						next_eng = ENG_IDLE;
					end
				end
			end
			default: next_eng = ENG_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			eng <= ENG_IDLE;
			trig <= RESET_CTRL_STATUS[POS_TRIGGER];
			dir <= RESET_CTRL_STATUS[POS_DIR];
			burst_select <= RESET_CTRL_STATUS[POS_BURST];
			err <= RESET_CTRL_STATUS[POS_ERR];
			dv <= RESET_CTRL_STATUS[POS_VALID];
			sz <= RESET_CTRL_STATUS[POS_SIZE +: 3];
			map <= RESET_CTRL_STATUS[POS_MAP +: 3];
			pr <= RESET_CTRL_STATUS[POS_PRIO +: 2];
			cnt <= RESET_CTRL_STATUS[POS_COUNT +: 14];
			addr <= RESET_WORD;
			data <= RESET_WORD;
			cur <= RESET_WORD;
			beats <= 15'h0;
			bptr <= 3'h0;
			rdy <= 1'b0;
			for (int i = 0; i < BURST_WORDS; i++) begin
				buf_mem[i] <= RESET_WORD;
			end
		end else begin
			eng <= next_eng;
			trig <= next_trig;
			dir <= next_dir;
			burst_select <= next_bst;
			err <= next_err;
			dv <= next_dv;
			sz <= next_sz;
			map <= next_map;
			pr <= next_pr;
			cnt <= next_cnt;
			addr <= next_addr;
			data <= next_data;
			cur <= next_cur;
			beats <= next_beats;
			bptr <= next_bptr;
			rdy <= next_rdy;
			buf_mem <= next_buf_mem;
		end
	end

	// ****************************************
	// Bus request and ready pin
	// ****************************************
	// Issued on its own, with no halt handshake and no translation step
	assign BUS_VALID = (eng == ENG_BUS);
	assign BUS_REQ.addr = cur;
	assign BUS_REQ.wdata = burst_select ? buf_mem[bptr] : (data & size_mask(bsz));
	assign BUS_REQ.size = bsz;
	assign BUS_REQ.write = dir;
	assign BUS_REQ.burst = burst_select;
	assign BUS_REQ.high_prio = (pr == PRIO_HIGHEST);
	assign RDY_N = ~rdy;
endmodule

// [verif/mem_access_chk.sv]
/*
 * Bus-side checks of the debug memory access engine.
 * Sees only the top ports; bound to the engine below the module.
 */
`timescale 1ns/10ps
module mem_access_chk (
	input wire logic CLK, // System clock
	input wire logic RSTN, // Reset, active low
	input wire logic RDY_N, // Done without error, active low
	input wire logic BUS_VALID, // Beat pending
	input wire mem_access_pkg::bus_req_s BUS_REQ, // Beat fields
	input wire logic BUS_ACK, // Beat done
	input wire logic BUS_ERR // Beat failed
);
	import mem_access_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// ********************
	// Bus beats
	// ********************
	req_hold_a: assert property (BUS_VALID && !BUS_ACK && !BUS_ERR
		|=> BUS_VALID && $stable(BUS_REQ)) else $error("request changed early");
	burst_word_a: assert property (BUS_VALID && BUS_REQ.burst
		|-> BUS_REQ.size == 2'h2 && BUS_REQ.addr[1:0] == 2'h0) else $error("burst beat shape");
	burst_step_a: assert property (BUS_VALID && BUS_ACK && BUS_REQ.burst ##1 BUS_VALID
		|-> BUS_REQ.addr == $past(BUS_REQ.addr) + 32'h4) else $error("burst step");
	single_step_a: assert property (BUS_VALID && BUS_ACK && !BUS_REQ.burst ##1 BUS_VALID
		|-> BUS_REQ.addr == $past(BUS_REQ.addr) + (32'h1 << $past(BUS_REQ.size)))
		else $error("single step");
	byte_mask_a: assert property (BUS_VALID && BUS_REQ.write && BUS_REQ.size == 2'h0
		|-> BUS_REQ.wdata[31:8] == 24'h0) else $error("byte data not masked");
	// ********************
	// Completion
	// ********************
	ready_cause_a: assert property ($fell(RDY_N)
		|-> $past(BUS_ACK) && $past(BUS_VALID)) else $error("ready without ack");
	err_noready_a: assert property (BUS_VALID && BUS_ERR
		|=> RDY_N && !BUS_VALID) else $error("error not ending transfer");
	ready_idle_a: assert property (!RDY_N |-> !BUS_VALID) else $error("ready while busy");
	cover property (BUS_VALID && BUS_REQ.burst && BUS_ACK);
	cover property (BUS_VALID && BUS_ERR);
	cover property ($fell(RDY_N));
endmodule
bind mem_access_engine mem_access_chk CHK (.CLK(CLK), .RSTN(RSTN), .RDY_N(RDY_N),
	.BUS_VALID(BUS_VALID), .BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK), .BUS_ERR(BUS_ERR));

// [verif/bus_mem_model.sv]
/*
 * System memory answering the engine's bus beats.
 * Assumes one beat at a time; wait and failure are set by the bench.
 */
`timescale 1ns/10ps
module bus_mem_model (
	input wire logic CLK, // System clock
	input wire logic RSTN, // Reset, active low
	input wire logic BUS_VALID, // Beat pending
	input wire mem_access_pkg::bus_req_s BUS_REQ, // Beat fields
	input wire logic [1:0] DELAY, // Wait cycles per beat
	input wire logic FAIL, // Answer with error
	output logic BUS_ACK, // Beat done
	output logic BUS_ERR, // Beat failed
	output logic [31:0] BUS_RDATA // Read data
);
	import mem_access_pkg::*;
	logic [31:0] mem [64];
	logic [1:0] wait_cnt;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wait_cnt <= 2'h0;
			BUS_ACK <= 1'h0;
			BUS_ERR <= 1'h0;
			BUS_RDATA <= 32'h0;
		end else begin
			BUS_ACK <= 1'h0;
			BUS_ERR <= 1'h0;
			// Data outside an answer is scrambled
			BUS_RDATA <= ~BUS_RDATA;
			if (BUS_VALID && !BUS_ACK && !BUS_ERR) begin
				wait_cnt <= wait_cnt + 2'h1;
				if (wait_cnt == DELAY) begin
					wait_cnt <= 2'h0;
					BUS_ERR <= FAIL;
					BUS_ACK <= !FAIL;
					if (BUS_REQ.write && !FAIL)
						mem[BUS_REQ.addr[7:2]] <= BUS_REQ.wdata;
					else if (!FAIL)
						BUS_RDATA <= mem[BUS_REQ.addr[7:2]] &
							~(32'hFFFFFFFF << (8 << BUS_REQ.size));
				end
			end
		end
	end
endmodule

// [verif/mem_access_engine_test.sv]
/*
 * Self-checking bench of the debug memory access engine.
 * Drives the JTAG pins; the memory model answers the bus.
 */
`timescale 1ns/10ps
module mem_access_engine_test;
	import mem_access_pkg::*;
	typedef struct packed {
		logic [2:0] size;
		logic [1:0] prio;
		logic [1:0] bsize;
		logic hi;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rexp;
	} row_s;
	row_s rows [6] = '{
		'{3'h0, 2'h0, 2'h0, 1'h0, 32'h40, 32'h123456DE, 32'hDE},
		'{3'h1, 2'h1, 2'h1, 1'h0, 32'h44, 32'h9999ADDE, 32'hADDE},
		'{3'h2, 2'h2, 2'h2, 1'h0, 32'h48, 32'hEFBEADDE, 32'hEFBEADDE},
		'{3'h3, 2'h3, 2'h2, 1'h1, 32'h4C, 32'h12345678, 32'h12345678},
		'{3'h4, 2'h3, 2'h2, 1'h1, 32'h50, 32'h9ABCDEF0, 32'h9ABCDEF0},
		'{3'h7, 2'h0, 2'h2, 1'h0, 32'h54, 32'h0F1E2D3C, 32'h0F1E2D3C}
	};
	logic CLK, RSTN, GATEWAY_SEL, TCK, TMS, TDI, TDO, RDY_N, BUS_VALID, BUS_ACK, BUS_ERR;
	logic fail, tdo_bit;
	logic [1:0] delay;
	logic [31:0] BUS_RDATA, q;
	bus_req_s BUS_REQ, last_req;
	int errors = 0, compares = 0, cycles = 0, beats = 0, b;
	mem_access_engine DUT (.CLK(CLK), .RSTN(RSTN), .GATEWAY_SEL(GATEWAY_SEL), .TCK(TCK),
		.TMS(TMS), .TDI(TDI), .TDO(TDO), .RDY_N(RDY_N), .BUS_VALID(BUS_VALID),
		.BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK), .BUS_ERR(BUS_ERR), .BUS_RDATA(BUS_RDATA));
	bus_mem_model MEM (.CLK(CLK), .RSTN(RSTN), .BUS_VALID(BUS_VALID), .BUS_REQ(BUS_REQ),
		.DELAY(delay), .FAIL(fail), .BUS_ACK(BUS_ACK), .BUS_ERR(BUS_ERR), .BUS_RDATA(BUS_RDATA));
	initial begin
		CLK = 1'h0;
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (BUS_VALID && (BUS_ACK || BUS_ERR)) begin
			beats <= beats + 1;
			last_req <= BUS_REQ;
		end
		if (cycles == 60000) begin
			errors++;
			print_verdict();
		end
	end
	// ********************
	// Tasks
	// ********************
	task automatic print_verdict();
		$display("Checks %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tck_step(input logic tms, input logic tdi);
		TCK <= 1'h0;
		TMS <= tms;
		TDI <= tdi;
		repeat (4) @(posedge CLK);
		tdo_bit = TDO;
		TCK <= 1'h1;
		repeat (4) @(posedge CLK);
	endtask
	task automatic dr_walk(input logic enter);
		tck_step(1'h1, 1'h0);
		tck_step(1'h0, 1'h0);
		if (enter)
			tck_step(1'h0, 1'h0);
	endtask
	task automatic reg_acc(input logic [6:0] idx, input logic wr, input logic [31:0] d);
		logic [7:0] sel;
		sel = {idx, wr};
		dr_walk(1'h1);
		for (int i = 0; i < 8; i++)
			tck_step(i == 7, sel[i]);
		dr_walk(1'h0);
		dr_walk(1'h1);
		for (int i = 0; i < 32; i++) begin
			tck_step(i == 31, d[i]);
			q[i] = tdo_bit;
		end
		dr_walk(1'h0);
	endtask
	function automatic logic [31:0] ctrl(logic wr, logic [2:0] sz, logic [1:0] pr, logic burst_select,
		logic [13:0] cnt);
		return {1'h1, wr, sz, 3'h0, pr, burst_select, 5'h0, cnt, 2'h0};
	endfunction
	task automatic start(input logic [31:0] a, input logic [31:0] c);
		b = beats;
		reg_acc(IDX_TARGET_ADDR, 1'h1, a);
		reg_acc(IDX_CTRL_STATUS, 1'h1, c);
	endtask
	task automatic wait_done(input int n);
		for (int i = 0; i < 400 && beats < n; i++)
			@(posedge CLK);
		repeat (2) @(posedge CLK);
	endtask
	task automatic status(input logic [2:0] exp);
		reg_acc(IDX_CTRL_STATUS, 1'h0, 32'h0);
		chk("status", {29'h0, exp}, {29'h0, q[31], q[1:0]});
	endtask
	task automatic run_row(input row_s r);
		start(r.addr, ctrl(1'h1, r.size, r.prio, 1'h0, 14'h1));
		status(3'h5);
		reg_acc(IDX_DATA_WORD, 1'h1, r.wdata);
		wait_done(b + 1);
		chk("ready", 32'h0, {31'h0, RDY_N});
		status(3'h0);
		chk("size", {30'h0, r.bsize}, {30'h0, last_req.size});
		chk("prio", {31'h0, r.hi}, {31'h0, last_req.high_prio});
		chk("addr", r.addr, last_req.addr);
		start(r.addr, ctrl(1'h0, r.size, r.prio, 1'h0, 14'h0));
		wait_done(b + 1);
		status(3'h1);
		reg_acc(IDX_DATA_WORD, 1'h0, 32'h0);
		chk("read data", r.rexp, q);
	endtask
	// ********************
	// Sequence
	// ********************
	initial begin
		RSTN = 1'h0;
		GATEWAY_SEL = 1'h1;
		TCK = 1'h0;
		TMS = 1'h1;
		TDI = 1'h0;
		delay = 2'h0;
		fail = 1'h0;
		repeat (16) @(posedge CLK);
		RSTN <= 1'h1;
		repeat (4) @(posedge CLK);
		chk("reset pins", 32'h2, {30'h0, RDY_N, BUS_VALID});
		repeat (5) tck_step(1'h1, 1'h0);
		tck_step(1'h0, 1'h0);
		reg_acc(IDX_CTRL_STATUS, 1'h0, 32'h0);
		chk("ctrl reset", RESET_CTRL_STATUS, q);
		GATEWAY_SEL <= 1'h0;
		reg_acc(IDX_TARGET_ADDR, 1'h1, 32'hFFFF);
		GATEWAY_SEL <= 1'h1;
		reg_acc(7'h05, 1'h0, 32'h0);
		chk("unknown index", 32'h0, q);
		reg_acc(IDX_TARGET_ADDR, 1'h0, 32'h0);
		chk("refused write", RESET_WORD, q);
		foreach (rows[i]) begin
			delay <= 2'(i);
			run_row(rows[i]);
		end
		start(32'h40, ctrl(1'h0, SZ_HALF, 2'h0, 1'h0, 14'h3));
		wait_done(b + 3);
		chk("beats", b + 3, beats);
		chk("last addr", 32'h44, last_req.addr);
		fail <= 1'h1;
		start(32'h40, ctrl(1'h0, SZ_WORD, 2'h0, 1'h0, 14'h1));
		wait_done(b + 1);
		fail <= 1'h0;
		status(3'h2);
		chk("ready on error", 32'h1, {31'h0, RDY_N});
		delay <= 2'h2;
		start(32'h87, ctrl(1'h1, SZ_DOUBLE, 2'h0, 1'h1, 14'h4));
		for (int i = 0; i < 8; i++) begin
			reg_acc(IDX_DATA_WORD, 1'h1, 32'hB0000000 + i);
			if (i == 3) begin
				reg_acc(IDX_DATA_WORD, 1'h0, 32'h0);
				chk("data mid burst", 32'hB0000003, q);
			end
		end
		wait_done(b + 8);
		chk("burst end", 32'h9C, last_req.addr);
		status(3'h0);
		start(32'h80, ctrl(1'h0, SZ_DOUBLE, 2'h3, 1'h1, 14'h4));
		wait_done(b + 8);
		status(3'h1);
		for (int i = 0; i < 8; i++) begin
			reg_acc(IDX_DATA_WORD, 1'h0, 32'h0);
			chk("burst data", 32'hB0000000 + i, q);
		end
		chk("ready before reset", 32'h0, {31'h0, RDY_N});
		RSTN <= 1'h0;
		repeat (2) @(posedge CLK);
		chk("pins in reset", 32'h2, {30'h0, RDY_N, BUS_VALID});
		RSTN <= 1'h1;
		repeat (5) tck_step(1'h1, 1'h0);
		tck_step(1'h0, 1'h0);
		reg_acc(IDX_DATA_WORD, 1'h0, 32'h0);
		chk("data after reset", RESET_WORD, q);
		reg_acc(IDX_CTRL_STATUS, 1'h0, 32'h0);
		chk("ctrl after reset", RESET_CTRL_STATUS, q);
		print_verdict();
	end
endmodule
